// ### hw/bsn_boot_select.sv
// Purpose: Non-volatile config bits, boot mapping, fast programming port gating
// Assumes: Pins are asynchronous; programmer handshake on req/ack levels
// Notes: Straps are sampled once the synchroniser has refilled after reset
// Function
// - Three non-volatile config bits, each set by command; bits 1 and 2 also cleared by command
// - Processor always fetches from address zero after reset
// - Bit 1 set maps flash at boot address, cleared maps ROM
// - Bit 1 zero shows ROM boot program at address zero
// - Unprogrammed default boots from ROM
// - Erase pin clears bit 1
// - Port accepts read, program, erases, lock, unlock, protect commands
// - Port reached over JTAG or handshaked parallel port
// - Security bit 0 blocks debug and programming port access
// - Security set by command only; cleared by erase pin then full erase
`timescale 1ns/1ps
module bsn_boot_select
  import bsn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic nv_set_req,
  input wire logic nv_clr_req,
  input wire logic [1:0] nv_bit_sel,
  input wire logic erase_pin,
  input wire logic test_strap_pin,
  input wire logic port_a_line_zero,
  input wire logic port_a_line_one,
  input wire logic jtag_sel,
  input wire logic par_req,
  input wire logic [2:0] par_cmd,
  input wire logic jtag_cmd_valid,
  input wire logic [2:0] jtag_cmd,
  output logic par_ack,
  output logic [2:0] nv_config_bits,
  output logic [1:0] boot_map,
  output logic [31:0] fetch_addr,
  output logic [31:0] boot_base,
  output logic fast_prog_mode,
  output logic access_blocked,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic cmd_rejected
);
  logic erase_s, tst_s, pa0_s, pa1_s, preq_s;
  logic sampled_ff;
  logic [1:0] settle_ff;
  logic [2:0] nv_ff;
  logic erase_seen_ff;
  logic [1:0] map_ff;
  logic fpm_ff;
  logic ack_ff;
  logic cv_ff, rej_ff;
  logic [2:0] code_ff;
  logic take;
  bsn_cmd_t cmd_in;

  bsn_sync #(.W(5)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({erase_pin, test_strap_pin, port_a_line_zero, port_a_line_one, par_req}),
    .q({erase_s, tst_s, pa0_s, pa1_s, preq_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nv_ff <= BSN_NV_RESET;
      erase_seen_ff <= 1'b0;
    end else begin
      if (nv_set_req && nv_bit_sel < 2'(BSN_NV_BITS)) begin
        nv_ff[nv_bit_sel] <= 1'b1;
      end else if (nv_clr_req && nv_bit_sel < 2'(BSN_NV_BITS)
                   && nv_bit_sel != 2'(BSN_SEC_BIT)) begin
        nv_ff[nv_bit_sel] <= 1'b0;
      end
      if (erase_seen_ff && take && cmd_in == BSN_CMD_FULL_ERASE) begin
        nv_ff[BSN_SEC_BIT] <= 1'b0;
        erase_seen_ff <= 1'b0;
      end
      // Erase pin seen in the same cycle as a full erase wins
      if (erase_s) begin
        nv_ff[BSN_BOOT_BIT] <= 1'b0;
        erase_seen_ff <= 1'b1;
      end
    end
  end
  assign nv_config_bits = nv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset-release sampling of mapping and straps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sampled_ff <= 1'b0;
      settle_ff <= 2'h0;
      map_ff <= BSN_MAP_ROM;
      fpm_ff <= 1'b0;
    end else if (!sampled_ff) begin
      // Synchroniser holds zeros through reset; wait until it shows the pins
      if (settle_ff != 2'(BSN_SETTLE_CYCLES)) begin
        settle_ff <= settle_ff + 2'h1;
      end else begin
        sampled_ff <= 1'b1;
        map_ff <= nv_ff[BSN_BOOT_BIT] ? BSN_MAP_FLASH : BSN_MAP_ROM;
        fpm_ff <= !tst_s && !pa0_s && !pa1_s;
      end
    end
  end
  assign boot_map = map_ff;
  assign boot_base = (map_ff == BSN_MAP_FLASH) ? BSN_FLASH_BASE : BSN_ROM_BASE;
  assign fetch_addr = BSN_BOOT_ADDR;
  assign fast_prog_mode = fpm_ff;
  assign access_blocked = nv_ff[BSN_SEC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Fast programming port, JTAG or four-phase parallel handshake
  assign cmd_in = bsn_cmd_t'(jtag_sel ? jtag_cmd : par_cmd);
  assign take = fpm_ff && (jtag_sel ? jtag_cmd_valid : (preq_s && !ack_ff));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else if (!jtag_sel && fpm_ff) begin
      if (preq_s && !ack_ff) ack_ff <= 1'b1;
      else if (!preq_s) ack_ff <= 1'b0;
    end else begin
      ack_ff <= 1'b0;
    end
  end
  assign par_ack = ack_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cv_ff <= 1'b0;
      rej_ff <= 1'b0;
      code_ff <= 3'h0;
    end else begin
      cv_ff <= 1'b0;
      rej_ff <= 1'b0;
      if (take) begin
        code_ff <= cmd_in;
        if (cmd_in == BSN_CMD_NONE) rej_ff <= 1'b1;
        else if (nv_ff[BSN_SEC_BIT] && cmd_in != BSN_CMD_FULL_ERASE) rej_ff <= 1'b1;
        else if (nv_ff[BSN_SEC_BIT] && !erase_seen_ff) rej_ff <= 1'b1;
        else cv_ff <= 1'b1;
      end
    end
  end
  assign cmd_valid = cv_ff;
  assign cmd_code = code_ff;
  assign cmd_rejected = rej_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_erase_boot: assert property (@(posedge clk) disable iff (reset)
    erase_s |=> !nv_ff[BSN_BOOT_BIT]) else $error("erase left boot bit set");
  a_boot_map: assert property (@(posedge clk) disable iff (reset)
    $rose(sampled_ff) |-> (map_ff == BSN_MAP_FLASH) == $past(nv_ff[BSN_BOOT_BIT]))
    else $error("boot map mismatch");
  a_map_fixed: assert property (@(posedge clk) disable iff (reset)
    sampled_ff && $past(sampled_ff) |-> $stable(map_ff) && $stable(fpm_ff))
    else $error("map changed after release");
  a_rom_default: assert property (@(posedge clk) disable iff (reset)
    $rose(sampled_ff) && !$past(nv_ff[BSN_BOOT_BIT]) |-> boot_base == BSN_ROM_BASE)
    else $error("default not ROM");
  a_fetch_zero: assert property (@(posedge clk) disable iff (reset)
    fetch_addr == BSN_BOOT_ADDR) else $error("fetch not zero");
  a_sec_block: assert property (@(posedge clk) disable iff (reset)
    take && nv_ff[BSN_SEC_BIT] && cmd_in != BSN_CMD_FULL_ERASE |=> rej_ff && !cv_ff)
    else $error("secured access passed");
  a_sec_hold: assert property (@(posedge clk) disable iff (reset)
    nv_ff[BSN_SEC_BIT] && !erase_seen_ff |=> nv_ff[BSN_SEC_BIT])
    else $error("security cleared without erase");
  a_cmd_set: assert property (@(posedge clk) disable iff (reset)
    nv_set_req && nv_bit_sel == 2'h2 |=> nv_ff[2]) else $error("set failed");
  a_strap_mode: assert property (@(posedge clk) disable iff (reset)
    !sampled_ff && settle_ff == 2'(BSN_SETTLE_CYCLES) && !tst_s && !pa0_s && !pa1_s |=> fpm_ff)
    else $error("no prog mode");
  a_ack_cmd: assert property (@(posedge clk) disable iff (reset)
    take && !nv_ff[BSN_SEC_BIT] && cmd_in != BSN_CMD_NONE |=> cv_ff)
    else $error("command dropped");

  ////////////////////////////////////////////////////////////////////////////
  // Command port, boot base and config bit checks
  a_reject_none: assert property (@(posedge clk) disable iff (reset)
    take && cmd_in == BSN_CMD_NONE |=> rej_ff && !cv_ff)
    else $error("unknown command accepted");
  a_one_result: assert property (@(posedge clk) disable iff (reset)
    !(cv_ff && rej_ff)) else $error("accept and reject together");
  a_code_hold: assert property (@(posedge clk) disable iff (reset)
    !take |=> $stable(code_ff)) else $error("command code moved");
  a_no_mode_take: assert property (@(posedge clk) disable iff (reset)
    !fpm_ff |=> !cv_ff && !rej_ff) else $error("command outside prog mode");
  a_ack_rise: assert property (@(posedge clk) disable iff (reset)
    !jtag_sel && fpm_ff && preq_s && !ack_ff |=> ack_ff) else $error("ack missing");
  a_ack_fall: assert property (@(posedge clk) disable iff (reset)
    !jtag_sel && !preq_s |=> !ack_ff) else $error("ack stuck high");
  a_flash_base: assert property (@(posedge clk) disable iff (reset)
    map_ff == BSN_MAP_FLASH |-> boot_base == BSN_FLASH_BASE) else $error("flash base wrong");
  a_rom_base: assert property (@(posedge clk) disable iff (reset)
    map_ff == BSN_MAP_ROM |-> boot_base == BSN_ROM_BASE) else $error("rom base wrong");
  a_sec_noclr: assert property (@(posedge clk) disable iff (reset)
    nv_clr_req && !nv_set_req && nv_bit_sel == 2'(BSN_SEC_BIT) && !take
    |=> nv_ff[BSN_SEC_BIT] == $past(nv_ff[BSN_SEC_BIT])) else $error("security cleared by cmd");
  a_sec_set: assert property (@(posedge clk) disable iff (reset)
    nv_set_req && nv_bit_sel == 2'(BSN_SEC_BIT) && !take |=> nv_ff[BSN_SEC_BIT])
    else $error("security set failed");
  a_sec_erase_ok: assert property (@(posedge clk) disable iff (reset)
    take && cmd_in == BSN_CMD_FULL_ERASE && erase_seen_ff |=> cv_ff)
    else $error("full erase refused after erase pin");
  a_clr_bit: assert property (@(posedge clk) disable iff (reset)
    nv_clr_req && !nv_set_req && nv_bit_sel == 2'(BSN_BOOT_BIT) |=> !nv_ff[BSN_BOOT_BIT])
    else $error("clear failed");
  // Cover points for the main scenarios
  c_flash_boot: cover property (@(posedge clk) $rose(sampled_ff) && map_ff == BSN_MAP_FLASH);
  c_prog_mode: cover property (@(posedge clk) $rose(fpm_ff));
  c_par_cmd: cover property (@(posedge clk) $rose(par_ack));
  c_sec_clear: cover property (@(posedge clk) $fell(nv_ff[BSN_SEC_BIT]));
endmodule : bsn_boot_select

// ### hw/bsn_pkg.sv
// Purpose: Shared constants for the boot select and non-volatile config block
// Assumes: Single 20 MHz clock domain
// Notes: Bit indices of the non-volatile configuration word
package bsn_pkg;
  localparam int BSN_NV_BITS = 3;
  localparam int BSN_SEC_BIT = 0;
  localparam int BSN_BOOT_BIT = 1;
  localparam int BSN_SETTLE_CYCLES = 2;
  localparam logic [2:0] BSN_NV_RESET = 3'h0;
  localparam logic [31:0] BSN_BOOT_ADDR = 32'h00000000;
  localparam logic [31:0] BSN_ROM_BASE = 32'h00800000;
  localparam logic [31:0] BSN_FLASH_BASE = 32'h00400000;
  localparam logic [1:0] BSN_MAP_ROM = 2'h0;
  localparam logic [1:0] BSN_MAP_FLASH = 2'h1;
  typedef enum logic [2:0] {
    BSN_CMD_READ, BSN_CMD_PAGE_PROG, BSN_CMD_PAGE_ERASE, BSN_CMD_FULL_ERASE,
    BSN_CMD_LOCK, BSN_CMD_UNLOCK, BSN_CMD_PROTECT, BSN_CMD_NONE
  } bsn_cmd_t;
endpackage : bsn_pkg

// ### hw/bsn_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Async reset to zero
// Notes: First stage read only by second
`timescale 1ns/1ps
module bsn_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : bsn_sync

// ### verification/bsn_boot_select_tb_top.sv
// Purpose: Self-checking bench for boot select and config bits
// Assumes: Inputs driven on the falling edge
// Notes: Port results are checked against a queue of notes
`timescale 1ns/1ps
module bsn_boot_select_tb_top;
  import bsn_pkg::*;
  logic clk, reset, nv_set_req, nv_clr_req, erase_pin, jtag_sel, jtag_cmd_valid, start, busy;
  logic test_strap_pin, port_a_line_zero, port_a_line_one, par_req, par_ack;
  logic fast_prog_mode, access_blocked, cmd_valid, cmd_rejected;
  logic [1:0] nv_bit_sel, lag, boot_map;
  logic [2:0] jtag_cmd, cmd_in, par_cmd, nv_config_bits, cmd_code, c;
  logic [31:0] fetch_addr, boot_base;
  logic [3:0] exp_q[$];
  logic [3:0] e;
  int n_mismatch = 0, tests_run = 0, seed = 63667;
  bsn_boot_select dut_u (.*);
  bsn_prog_model prog_u (.*);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic nvc(input logic s, input logic r, input logic [1:0] b);
    {nv_set_req, nv_clr_req, nv_bit_sel} = {s, r, b};
    @(negedge clk);
    {nv_set_req, nv_clr_req} = 2'h0;
    @(negedge clk);
  endtask : nvc
  task automatic jt(input logic [2:0] k, input logic r);
    exp_q.push_back({r, k});
    {jtag_cmd_valid, jtag_cmd} = {1'h1, k};
    @(negedge clk);
    jtag_cmd_valid = 1'h0;
    repeat (2) @(negedge clk);
  endtask : jt
  task automatic rst(input logic [2:0] s, input logic fb);
    {test_strap_pin, port_a_line_zero, port_a_line_one, reset} = {s, 1'h1};
    repeat (3) @(negedge clk);
    reset = 1'h0;
    {nv_set_req, nv_bit_sel} = {fb, 2'(BSN_BOOT_BIT)};
    @(negedge clk);
    nv_set_req = 1'h0;
    repeat (3) @(negedge clk);
  endtask : rst
  task automatic erase_hold;
    erase_pin = 1'h1;
    repeat (4) @(negedge clk);
    erase_pin = 1'h0;
    repeat (3) @(negedge clk);
  endtask : erase_hold
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(negedge clk) if (cmd_valid === 1'h1 || cmd_rejected === 1'h1) begin
    chk("note", 32'h1, {31'h0, exp_q.size() > 0});
    e = exp_q.pop_front();
    chk("cmd", e, {cmd_rejected, cmd_code});
  end
  initial begin
    {nv_set_req, nv_clr_req, nv_bit_sel, erase_pin, jtag_sel, jtag_cmd_valid} = '0;
    {jtag_cmd, start, cmd_in, lag} = '0;
    rst(3'h7, 1'h0);
    chk("nv", BSN_NV_RESET, nv_config_bits);
    chk("map", BSN_MAP_ROM, boot_map);
    chk("base", BSN_ROM_BASE, boot_base);
    chk("fetch", BSN_BOOT_ADDR, fetch_addr);
    chk("fpm", 32'h0, fast_prog_mode);
    nvc(1'h1, 1'h0, 2'h1);
    nvc(1'h1, 1'h1, 2'h2);
    chk("nv", 32'h6, nv_config_bits);
    nvc(1'h0, 1'h1, 2'h2);
    chk("nv", 32'h2, nv_config_bits);
    chk("map", BSN_MAP_ROM, boot_map);
    erase_hold();
    chk("nv", 32'h0, nv_config_bits);
    rst(3'h0, 1'h0);
    chk("fpm", 32'h1, fast_prog_mode);
    jtag_sel = 1'h1;
    for (int i = 0; i < 16; i++) begin
      c = (i < 8) ? i[2:0] : 3'($random(seed));
      jt(c, c == BSN_CMD_NONE);
    end
    jtag_sel = 1'h0;
    for (int i = 0; i < 4; i += 3) begin
      exp_q.push_back({1'h0, BSN_CMD_PAGE_ERASE});
      {cmd_in, lag} = {BSN_CMD_PAGE_ERASE, i[1:0]};
      start <= 1'h1;
      @(negedge clk);
      start <= 1'h0;
      @(negedge clk);
      for (int n = 0; n < 40 && busy !== 1'h0; n++) @(negedge clk);
    end
    jtag_sel = 1'h1;
    nvc(1'h1, 1'h0, 2'h0);
    chk("blk", 32'h1, access_blocked);
    jt(BSN_CMD_READ, 1'h1);
    nvc(1'h0, 1'h1, 2'h0);
    chk("blk", 32'h1, access_blocked);
    jt(BSN_CMD_FULL_ERASE, 1'h1);
    erase_hold();
    jt(BSN_CMD_FULL_ERASE, 1'h0);
    chk("blk", 32'h0, access_blocked);
    chk("left", 32'h0, exp_q.size());
    rst(3'h7, 1'h1);
    chk("map", BSN_MAP_FLASH, boot_map);
    chk("base", BSN_FLASH_BASE, boot_base);
    chk("fpm", 32'h0, fast_prog_mode);
    chk("nv", 32'h2, nv_config_bits);
    tally_and_finish();
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : bsn_boot_select_tb_top

// ### verification/bsn_prog_model.sv
// Purpose: Parallel-port programmer model with a four-phase handshake
// Assumes: Drives on the falling clock edge
// Notes: Command lines are inverted once the request is released
`timescale 1ns/1ps
module bsn_prog_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [2:0] cmd_in,
  input wire logic [1:0] lag,
  input wire logic par_ack,
  output logic par_req,
  output logic [2:0] par_cmd,
  output logic busy
);
  task automatic wait_ack(input logic lvl);
    for (int n = 0; n < 20 && par_ack !== lvl; n++) @(negedge clk);
  endtask : wait_ack
  initial begin
    par_req = 1'h0;
    par_cmd = 3'h0;
    busy = 1'h0;
    forever begin
      @(negedge clk);
      if (start) begin
        busy = 1'h1;
        par_cmd = cmd_in;
        par_req = 1'h1;
        wait_ack(1'h1);
        repeat (lag) @(negedge clk);
        par_req = 1'h0;
        par_cmd = ~cmd_in;
        wait_ack(1'h0);
        busy = 1'h0;
      end
    end
  end
endmodule : bsn_prog_model
